// [core/peak_flags_defs.vh]
// Constants of the peak-hold, energy-flag and low-power register slice.
// Assumes 16-bit register addresses from the serial port engine.
`ifndef PEAK_FLAGS_DEFS_VH
`define PEAK_FLAGS_DEFS_VH

// Register addresses
`define ADDR_CURRENT_PEAK_HOLD 16'hE500
`define ADDR_VOLTAGE_PEAK_HOLD 16'hE501
`define ADDR_ENERGY_EVENT_FLAGS 16'hE502
`define ADDR_THIRD_HARMONIC_SEL 16'hEA0A
`define ADDR_RESERVED_LO 16'hEA0B
`define ADDR_RESERVED_HI 16'hEBFE
`define ADDR_PORT_LOCK 16'hEBFF
`define ADDR_LOW_POWER_OC_LEVEL 16'hEC00
`define ADDR_STANDBY_MODE_ONE 16'hEC01

// Reset values
`define RST_THIRD_HARMONIC_SEL 8'h07
`define RST_LOW_POWER_OC_LEVEL 8'h07
`define RST_STANDBY_MODE_ONE 8'h00

// Peak-hold field positions
`define PEAK_VALUE_MSB 23
`define PEAK_PHASE_LSB 24
`define PEAK_PHASE_MSB 26

// Energy event flag bit positions
`define FLAG_TOTAL_ACTIVE 0
`define FLAG_FUND_ACTIVE 1
`define FLAG_RESERVED 2
`define FLAG_FUND_REACTIVE 3
`define FLAG_APPARENT 4
`define FLAG_LINE_CYCLE 5
`define FLAG_COUNT 6

// Accumulator bit watched for half-full events
`define ENERGY_WATCH_BIT 30

// Transmission formats of a read word
`define FMT_BYTE 3'h0
`define FMT_ZP10 3'h1
`define FMT_ZP20 3'h2
`define FMT_ZP24 3'h3
`define FMT_SE24 3'h4
`define FMT_WORD32 3'h5

// Read length codes on reg_rlen
`define RLEN_8 2'h0
`define RLEN_16 2'h1
`define RLEN_32 2'h2

`endif

// [core/phase_peak_detect.v]
// Three-phase peak detector with source-phase indication.
// Assumes signed two's complement samples on the system clock.
module phase_peak_detect #(
    parameter W = 24
) (
    input wire clk_sys,
    input wire rst,
    input wire [W-1:0] sample_a,
    input wire [W-1:0] sample_b,
    input wire [W-1:0] sample_c,
    input wire sample_valid,
    output reg [W-1:0] peak_value,
    output reg [2:0] peak_phase
);

    // Magnitude of a two's complement sample; the most negative code fits unsigned
    function [W-1:0] magnitude;
        input [W-1:0] s;
        begin
            if (s[W-1]) begin
                magnitude = (~s) + {{(W-1){1'b0}}, 1'b1};
            end else begin
                magnitude = s;
            end
        end
    endfunction

    wire [W-1:0] mag_a;
    wire [W-1:0] mag_b;
    wire [W-1:0] mag_c;
    reg [W-1:0] largest;
    reg [2:0] largest_phase;

    assign mag_a = magnitude(sample_a);
    assign mag_b = magnitude(sample_b);
    assign mag_c = magnitude(sample_c);

    // Largest magnitude of the three, with every phase that reaches it
    always @* begin
        largest = mag_a;
        if (mag_b > largest) begin
            largest = mag_b;
        end
        if (mag_c > largest) begin
            largest = mag_c;
        end
        largest_phase[0] = (mag_a == largest);
        largest_phase[1] = (mag_b == largest);
        largest_phase[2] = (mag_c == largest);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Update on larger sample
    always @(posedge clk_sys) begin
        if (rst) begin
            peak_value <= {W{1'b0}};
            peak_phase <= 3'h0;
        end else if (sample_valid && (largest > peak_value)) begin
            peak_value <= largest;
            peak_phase <= largest_phase;
        end
    end

endmodule // phase_peak_detect

// [core/peak_energy_regs.v]
// Register slice: peak-hold registers, energy event flags, harmonic index
// selector and low-power settings, read and written by the serial port engine.
// Assumes all inputs come from logic on clk_sys; the serial framing lies outside.
`include "peak_flags_defs.vh"

module peak_energy_regs #(
    parameter SAMPLE_W = 24
) (
    input wire clk_sys,
    input wire rst,
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    output reg [1:0] reg_rlen,
    output reg reg_rvalid,
    input wire spi_active,
    output reg port_lock_pulse,
    output reg [7:0] port_lock_data,
    input wire [SAMPLE_W-1:0] current_sample_a,
    input wire [SAMPLE_W-1:0] current_sample_b,
    input wire [SAMPLE_W-1:0] current_sample_c,
    input wire current_sample_valid,
    input wire [SAMPLE_W-1:0] voltage_sample_a,
    input wire [SAMPLE_W-1:0] voltage_sample_b,
    input wire [SAMPLE_W-1:0] voltage_sample_c,
    input wire voltage_sample_valid,
    input wire [2:0] total_active_bit30,
    input wire [2:0] fund_active_bit30,
    input wire [2:0] fund_reactive_bit30,
    input wire [2:0] apparent_bit30,
    input wire line_cycle_mode,
    input wire line_cycle_done,
    output reg [7:0] third_harmonic_index_select,
    output reg [7:0] low_power_overcurrent_level,
    output reg [7:0] standby_mode_one_setup,
    output reg [5:0] energy_event_flags
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Shapes a register value into its transmitted word
    function [31:0] fmt_word;
        input [31:0] value;
        input [2:0] code;
        begin
            case (code)
                `FMT_BYTE: begin
                    fmt_word = {24'h000000, value[7:0]};
                end
                `FMT_ZP10: begin
                    fmt_word = {22'h00000, value[9:0]};
                end
                `FMT_ZP20: begin
                    fmt_word = {12'h000, value[19:0]};
                end
                `FMT_ZP24: begin
                    fmt_word = {8'h00, value[23:0]};
                end
                `FMT_SE24: begin
                    fmt_word = {{8{value[23]}}, value[23:0]};
                end
                default: begin
                    fmt_word = value;
                end
            endcase
        end
    endfunction

    // Read length code that goes with a format
    function [1:0] fmt_len;
        input [2:0] code;
        begin
            case (code)
                `FMT_BYTE: begin
                    fmt_len = `RLEN_8;
                end
                `FMT_ZP10: begin
                    fmt_len = `RLEN_16;
                end
                default: begin
                    fmt_len = `RLEN_32;
                end
            endcase
        end
    endfunction

    // Any of three accumulators changed its watched bit
    function any_change;
        input [2:0] now_bits;
        input [2:0] prev_bits;
        begin
            any_change = |(now_bits ^ prev_bits);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Peak detectors

    wire [SAMPLE_W-1:0] current_peak_value;
    wire [2:0] current_peak_source_phase;
    wire [SAMPLE_W-1:0] voltage_peak_value;
    wire [2:0] voltage_peak_source_phase;

    phase_peak_detect #(
        .W(SAMPLE_W)
    ) u_current_peak (
        .clk_sys(clk_sys),
        .rst(rst),
        .sample_a(current_sample_a),
        .sample_b(current_sample_b),
        .sample_c(current_sample_c),
        .sample_valid(current_sample_valid),
        .peak_value(current_peak_value),
        .peak_phase(current_peak_source_phase)
    );

    phase_peak_detect #(
        .W(SAMPLE_W)
    ) u_voltage_peak (
        .clk_sys(clk_sys),
        .rst(rst),
        .sample_a(voltage_sample_a),
        .sample_b(voltage_sample_b),
        .sample_c(voltage_sample_c),
        .sample_valid(voltage_sample_valid),
        .peak_value(voltage_peak_value),
        .peak_phase(voltage_peak_source_phase)
    );

    wire [31:0] current_peak_hold;
    wire [31:0] voltage_peak_hold;

    assign current_peak_hold = {5'h00, current_peak_source_phase,
                                current_peak_value[`PEAK_VALUE_MSB:0]};
    assign voltage_peak_hold = {5'h00, voltage_peak_source_phase,
                                voltage_peak_value[`PEAK_VALUE_MSB:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Energy accumulator bit-30 watch

    reg [2:0] prev_total_active;
    reg [2:0] prev_fund_active;
    reg [2:0] prev_fund_reactive;
    reg [2:0] prev_apparent;
    reg watch_primed;

    // Previous values are captured every cycle out of reset and cleared in reset; watch_primed holds off the first cycle after reset so it flags nothing
    always @(posedge clk_sys) begin
        if (rst) begin
            prev_total_active <= 3'h0;
            prev_fund_active <= 3'h0;
            prev_fund_reactive <= 3'h0;
            prev_apparent <= 3'h0;
            watch_primed <= 1'b0;
        end else begin
            prev_total_active <= total_active_bit30;
            prev_fund_active <= fund_active_bit30;
            prev_fund_reactive <= fund_reactive_bit30;
            prev_apparent <= apparent_bit30;
            watch_primed <= 1'b1;
        end
    end

    reg [5:0] flag_set;

    always @* begin
        flag_set = 6'h00;
        flag_set[`FLAG_TOTAL_ACTIVE] = watch_primed &&
            any_change(total_active_bit30, prev_total_active);
        flag_set[`FLAG_FUND_ACTIVE] = watch_primed &&
            any_change(fund_active_bit30, prev_fund_active);
        flag_set[`FLAG_FUND_REACTIVE] = watch_primed &&
            any_change(fund_reactive_bit30, prev_fund_reactive);
        flag_set[`FLAG_APPARENT] = watch_primed &&
            any_change(apparent_bit30, prev_apparent);
        flag_set[`FLAG_LINE_CYCLE] = line_cycle_mode && line_cycle_done;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes

    wire wr_flags;
    wire [5:0] flag_clear;
    reg [5:0] next_flags;

    assign wr_flags = reg_wr && (reg_addr == `ADDR_ENERGY_EVENT_FLAGS);
    assign flag_clear = wr_flags ? reg_wdata[5:0] : 6'h00;

    always @* begin
        next_flags = (energy_event_flags & ~flag_clear) | flag_set;
        next_flags[`FLAG_RESERVED] = 1'b0;
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            energy_event_flags <= 6'h00;
        end else begin
            energy_event_flags <= next_flags;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            third_harmonic_index_select <= `RST_THIRD_HARMONIC_SEL;
            low_power_overcurrent_level <= `RST_LOW_POWER_OC_LEVEL;
            standby_mode_one_setup <= `RST_STANDBY_MODE_ONE;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_THIRD_HARMONIC_SEL: begin
                    third_harmonic_index_select <= reg_wdata[7:0];
                end
                `ADDR_LOW_POWER_OC_LEVEL: begin
                    low_power_overcurrent_level <= reg_wdata[7:0];
                end
                `ADDR_STANDBY_MODE_ONE: begin
                    standby_mode_one_setup <= reg_wdata[7:0];
                end
                default: begin
                    third_harmonic_index_select <= third_harmonic_index_select;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port lock address

    wire port_lock_hit;

    assign port_lock_hit = (reg_addr == `ADDR_PORT_LOCK) && (reg_wr || reg_rd);

    always @(posedge clk_sys) begin
        if (rst) begin
            port_lock_pulse <= 1'b0;
            port_lock_data <= 8'h00;
        end else begin
            port_lock_pulse <= port_lock_hit && spi_active;
            if (port_lock_hit && spi_active && reg_wr) begin
                port_lock_data <= reg_wdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads

    reg [31:0] read_value;
    reg [2:0] read_fmt;

    always @* begin
        read_value = 32'h00000000;
        read_fmt = `FMT_BYTE;
        case (reg_addr)
            `ADDR_CURRENT_PEAK_HOLD: begin
                read_value = current_peak_hold;
                read_fmt = `FMT_WORD32;
            end
            `ADDR_VOLTAGE_PEAK_HOLD: begin
                read_value = voltage_peak_hold;
                read_fmt = `FMT_WORD32;
            end
            `ADDR_ENERGY_EVENT_FLAGS: begin
                read_value = {26'h000000, energy_event_flags};
                read_fmt = `FMT_WORD32;
            end
            `ADDR_THIRD_HARMONIC_SEL: begin
                read_value = {24'h000000, third_harmonic_index_select};
            end
            `ADDR_LOW_POWER_OC_LEVEL: begin
                read_value = {24'h000000, low_power_overcurrent_level};
            end
            `ADDR_STANDBY_MODE_ONE: begin
                read_value = {24'h000000, standby_mode_one_setup};
            end
            default: begin
                read_value = 32'h00000000;
                read_fmt = `FMT_BYTE;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
            reg_rlen <= `RLEN_8;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= fmt_word(read_value, read_fmt);
                reg_rlen <= fmt_len(read_fmt);
            end
        end
    end

endmodule // peak_energy_regs

// [test/peak_regs_chk.sv]
// Checker of the peak, flag and low-power register slice.
// Assumes binding onto peak_energy_regs; sees only its ports.
module peak_regs_chk (
    input wire clk_sys,
    input wire rst,
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    input wire [1:0] reg_rlen,
    input wire reg_rvalid,
    input wire spi_active,
    input wire port_lock_pulse,
    input wire [7:0] port_lock_data,
    input wire [2:0] total_active_bit30,
    input wire line_cycle_mode,
    input wire line_cycle_done,
    input wire [7:0] third_harmonic_index_select,
    input wire [7:0] low_power_overcurrent_level,
    input wire [7:0] standby_mode_one_setup,
    input wire [5:0] energy_event_flags
);
    timeunit 1ns;
    timeprecision 1ps;
    logic armed;
    logic clr0;
    // Bit-30 watch only counts after its priming edge
    always @(posedge clk_sys) armed <= !rst;
    assign clr0 = reg_wr && reg_addr == 16'hE502 && reg_wdata[0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    a_sel_write: assert property (reg_wr && reg_addr == 16'hEA0A |=>
        third_harmonic_index_select == $past(reg_wdata[7:0])) else $error("selector write lost");
    a_reserved_zero: assert property (reg_rd && reg_addr inside {[16'hEA0B:16'hEBFE]} |=>
        reg_rvalid && reg_rdata == 32'h0 && reg_rlen == 2'h0) else $error("reserved not zero");
    a_lock_pulse: assert property (reg_wr && reg_addr == 16'hEBFF && spi_active |=>
        port_lock_pulse && port_lock_data == $past(reg_wdata[7:0])) else $error("no lock pulse");
    a_lock_cause: assert property (port_lock_pulse |->
        $past(spi_active && (reg_rd || reg_wr) && reg_addr == 16'hEBFF)) else $error("stray lock");
    a_oc_write: assert property (reg_wr && reg_addr == 16'hEC00 |=>
        low_power_overcurrent_level == $past(reg_wdata[7:0])) else $error("level write lost");
    a_setup_write: assert property (reg_wr && reg_addr == 16'hEC01 |=>
        standby_mode_one_setup == $past(reg_wdata[7:0])) else $error("setup write lost");
    a_peak_top_zero: assert property (reg_rd && reg_addr[15:1] == 15'h7280 |=>
        reg_rdata[31:27] == 5'h00 && reg_rlen == 2'h2) else $error("peak top bits set");
    a_total_set: assert property (armed && $changed(total_active_bit30) |=>
        energy_event_flags[0]) else $error("total flag missed");
    a_bit2_zero: assert property (energy_event_flags[2] == 1'b0)
        else $error("reserved flag set");
    a_cycle_done: assert property (line_cycle_done && line_cycle_mode |=>
        energy_event_flags[5]) else $error("line cycle flag missed");
    a_flag_hold: assert property (energy_event_flags[0] && !clr0 |=>
        energy_event_flags[0]) else $error("flag dropped");
    cover property (reg_rd && reg_addr == 16'hE500);
    cover property (port_lock_pulse);
    cover property (energy_event_flags[5]);
endmodule // peak_regs_chk

// [test/host_port_model.sv]
// Host side of the register strobe port.
// Assumes requests are launched and released at falling edges.
module host_port_model (
    input wire clk_sys,
    output logic [15:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    input wire [1:0] reg_rlen,
    input wire reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 32'h0;
    end
    ////////////////////////////////////////
    // Flags cleared by ones
    task automatic write(input logic [15:0] a, input logic [31:0] dat);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = dat;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~dat;
    endtask
    // Read data taken while it stands
    task automatic read(input logic [15:0] a, output logic [31:0] dat,
                        output logic [1:0] len, output logic ok);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        reg_addr = ~a;
        dat = reg_rdata;
        len = reg_rlen;
        ok = reg_rvalid;
    endtask
endmodule // host_port_model

// [test/peak_energy_regs_tb_top.sv]
// Self-checking bench of the peak, flag and low-power register slice.
// Assumes design and host model compiled first; inputs move at falling edges.
module peak_energy_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic spi_active = 1'b0;
    logic [23:0] ia = 24'h0, ib = 24'h0, ic = 24'h0, va = 24'h0, vb = 24'h0, vc = 24'h0;
    logic iv = 1'b0, vv = 1'b0, lc_mode = 1'b0, lc_done = 1'b0;
    logic [2:0] ta = 3'h0, fa = 3'h0, fr = 3'h0, ap = 3'h0;
    wire [15:0] reg_addr;
    wire reg_wr, reg_rd, reg_rvalid, port_lock_pulse;
    wire [31:0] reg_wdata, reg_rdata;
    wire [1:0] reg_rlen;
    wire [7:0] port_lock_data, sel, oc, setup;
    wire [5:0] flags;
    int err_total = 0, check_count = 0, cyc = 0, k, pos;
    logic [15:0] adr [4];
    logic [31:0] d;
    logic [1:0] n;
    logic v;

    always #12.5 clk_sys = ~clk_sys;

    peak_energy_regs #(.SAMPLE_W(24)) peak_energy_regs_i (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rlen(reg_rlen),
        .reg_rvalid(reg_rvalid), .spi_active(spi_active), .port_lock_pulse(port_lock_pulse),
        .port_lock_data(port_lock_data), .current_sample_a(ia), .current_sample_b(ib),
        .current_sample_c(ic), .current_sample_valid(iv), .voltage_sample_a(va),
        .voltage_sample_b(vb), .voltage_sample_c(vc), .voltage_sample_valid(vv),
        .total_active_bit30(ta), .fund_active_bit30(fa), .fund_reactive_bit30(fr),
        .apparent_bit30(ap), .line_cycle_mode(lc_mode), .line_cycle_done(lc_done),
        .third_harmonic_index_select(sel), .low_power_overcurrent_level(oc),
        .standby_mode_one_setup(setup), .energy_event_flags(flags)
    );
    host_port_model host_port_model_i (
        .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rlen(reg_rlen),
        .reg_rvalid(reg_rvalid)
    );
    ////////////////////////////////////////
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] len);
        host_port_model_i.read(a, d, n, v);
        chk_word(d, exp);
        chk_word({30'h0, n}, {30'h0, len});
        chk_bit(v, 1'b1);
    endtask
    // Held samples are inverted once valid drops
    task automatic feed(input bit volt, input logic [23:0] a, b, c);
        @(negedge clk_sys);
        if (volt) {va, vb, vc, vv} = {a, b, c, 1'b1};
        else {ia, ib, ic, iv} = {a, b, c, 1'b1};
        @(negedge clk_sys);
        {ia, ib, ic, iv, va, vb, vc, vv} = {~ia, ~ib, ~ic, 1'b0, ~va, ~vb, ~vc, 1'b0};
    endtask
    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            print_verdict;
        end
    end
    ////////////////////////////////////////
    initial begin
        adr = '{16'hEA0A, 16'hEC00, 16'hEC01, 16'h1234};
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        rd_chk(16'hE500, 32'h0, 2'h2);
        rd_chk(16'hE501, 32'h0, 2'h2);
        rd_chk(16'hE502, 32'h0, 2'h2);
        rd_chk(adr[0], 32'h07, 2'h0);
        rd_chk(adr[1], 32'h07, 2'h0);
        rd_chk(adr[2], 32'h00, 2'h0);
        for (k = 0; k < 3; k++) begin
            host_port_model_i.write(adr[k], 32'hFFFFFF50 + k);
            rd_chk(adr[k], 32'h50 + k, 2'h0);
        end
        chk_word({8'h00, sel, oc, setup}, 32'h00505152);
        adr = '{16'hEA0B, 16'hEBFE, 16'hEBFF, 16'h1234};
        for (k = 0; k < 4; k++) begin
            host_port_model_i.write(adr[k], 32'hFFFFFFFF);
            chk_bit(port_lock_pulse, 1'b0);
            rd_chk(adr[k], 32'h0, 2'h0);
        end
        chk_word({8'h00, sel, oc, setup}, 32'h00505152);
        spi_active = 1'b1;
        host_port_model_i.write(16'hEBFF, 32'h3C);
        chk_bit(port_lock_pulse, 1'b1);
        chk_word({24'h0, port_lock_data}, 32'h3C);
        @(negedge clk_sys);
        chk_bit(port_lock_pulse, 1'b0);
        rd_chk(16'hEBFF, 32'h0, 2'h0);
        chk_bit(port_lock_pulse, 1'b1);
        chk_word({24'h0, port_lock_data}, 32'h3C);
        feed(0, 24'h000000, 24'hFFFFFB, 24'h000000);
        rd_chk(16'hE500, 32'h02000005, 2'h2);
        feed(0, 24'h000003, 24'h0, 24'h0);
        rd_chk(16'hE500, 32'h02000005, 2'h2);
        feed(0, 24'h000100, 24'h0, 24'h000100);
        rd_chk(16'hE500, 32'h05000100, 2'h2);
        feed(1, 24'h0, 24'h0, 24'h7FFFFF);
        rd_chk(16'hE501, 32'h047FFFFF, 2'h2);
        feed(1, 24'h0, 24'h800000, 24'h0);
        rd_chk(16'hE501, 32'h02800000, 2'h2);
        for (k = 0; k < 4; k++) begin
            @(negedge clk_sys);
            case (k)
                0: ta[0] = ~ta[0];
                1: fa[1] = ~fa[1];
                2: fr[2] = ~fr[2];
                default: ap[0] = ~ap[0];
            endcase
            pos = (k < 2) ? k : k + 1;
            repeat (2) @(negedge clk_sys);
            chk_bit(flags[pos], 1'b1);
            host_port_model_i.write(16'hE502, 32'h0);
            chk_bit(flags[pos], 1'b1);
            host_port_model_i.write(16'hE502, 32'h1 << pos);
            chk_bit(flags[pos], 1'b0);
            @(negedge clk_sys);
            chk_bit(flags[pos], 1'b0);
        end
        lc_done = 1'b1;
        @(negedge clk_sys);
        lc_done = 1'b0;
        @(negedge clk_sys);
        chk_bit(flags[5], 1'b0);
        {lc_mode, lc_done} = 2'h3;
        @(negedge clk_sys);
        lc_done = 1'b0;
        rd_chk(16'hE502, 32'h20, 2'h2);
        host_port_model_i.write(16'hE502, 32'hFFFFFFFF);
        rd_chk(16'hE502, 32'h0, 2'h2);
        print_verdict;
    end
endmodule // peak_energy_regs_tb_top

bind peak_energy_regs peak_regs_chk peak_regs_chk_i (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rlen(reg_rlen),
    .reg_rvalid(reg_rvalid), .spi_active(spi_active), .port_lock_pulse(port_lock_pulse),
    .port_lock_data(port_lock_data), .total_active_bit30(total_active_bit30),
    .line_cycle_mode(line_cycle_mode), .line_cycle_done(line_cycle_done),
    .third_harmonic_index_select(third_harmonic_index_select),
    .low_power_overcurrent_level(low_power_overcurrent_level),
    .standby_mode_one_setup(standby_mode_one_setup), .energy_event_flags(energy_event_flags)
);
